/* common/vru_pkg.sv */
// Purpose: Shared constants and carriers for the vector AES round unit
// Assumes: Four 32-bit elements per 128-bit group, byte 0 in bits [7:0]
// Notes:   Mix coefficients hold c0 in the low byte
package vru_pkg;

    localparam int          GRP_W      = 128;
    localparam int          GRP_SHIFT  = 2;
    localparam int          IDX_W      = 16;
    localparam int          REG_W      = 5;
    localparam logic [2:0]  SEW_32     = 3'h2;
    localparam logic [6:0]  CRYPTO_OPC = 7'h77;
    localparam logic [2:0]  FUNCT_MVV  = 3'h2;
    localparam logic [5:0]  F6_VV      = 6'h28;
    localparam logic [5:0]  F6_VS      = 6'h29;
    localparam logic [4:0]  SEL_DM     = 5'h00;
    localparam logic [4:0]  SEL_DF     = 5'h01;
    localparam logic [4:0]  SEL_EM     = 5'h02;
    localparam logic [4:0]  SEL_EF     = 5'h03;
    localparam logic [7:0]  GF_POLY    = 8'h1b;
    localparam logic [7:0]  AFF_C      = 8'h63;
    localparam logic [7:0]  AFF_INV_C  = 8'h05;
    localparam logic [31:0] MIX_FWD    = 32'h01010302;
    localparam logic [31:0] MIX_INV    = 32'h090d0b0e;

    typedef enum logic [1:0] {
        OP_DF = 2'b00,
        OP_DM = 2'b01,
        OP_EF = 2'b10,
        OP_EM = 2'b11
    } vru_op_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_WAIT  = 2'b01,
        S_PUSH  = 2'b10,
        S_DRAIN = 2'b11
    } vru_st_t;

    typedef struct packed {
        logic [31:0]        instr;
        logic [2:0]         sew;
        logic signed [2:0]  register_grouping_log2;
        logic [IDX_W-1:0]   vector_length;
        logic [IDX_W-1:0]   start_index;
    } vru_cmd_t;

    typedef struct packed {
        logic [REG_W-1:0]   dest_state_group;
        logic [REG_W-1:0]   key_source_group;
        logic [IDX_W-1:0]   state_idx;
        logic [IDX_W-1:0]   key_idx;
    } vru_rd_t;

    typedef struct packed {
        logic [REG_W-1:0]   dest_state_group;
        logic [IDX_W-1:0]   grp_idx;
        logic [GRP_W-1:0]   data;
    } vru_wr_t;

endpackage : vru_pkg

/* hdl/vru_round.sv */
// Purpose: One AES round step on a 128-bit group, fixed combinational depth
// Assumes: Column c, row r sits in byte 4*c+r of the group
// Notes:   S-boxes are computed, not looked up, so no table timing leaks
`timescale 1ns/1ns
`default_nettype none

module vru_round
    import vru_pkg::*;
(
    input  wire vru_op_t          op,
    input  wire logic [GRP_W-1:0] state_in,
    input  wire logic [GRP_W-1:0] key_in,
    output logic      [GRP_W-1:0] result
);

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
        end
        return p;
    endfunction : gf_mul

    // Raises to the power 254, which maps zero to zero
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] acc;
        logic [7:0] sq;
        acc = 8'h01;
        sq  = a;
        for (int i = 1; i < 8; i++) begin
            sq  = gf_mul(sq, sq);
            acc = gf_mul(acc, sq);
        end
        return acc;
    endfunction : gf_inv

    function automatic logic [7:0] rotl(input logic [7:0] v, input int n);
        return (v << n) | (v >> (8 - n));
    endfunction : rotl

    function automatic logic [7:0] sbox_fwd(input logic [7:0] x);
        logic [7:0] i;
        i = gf_inv(x);
        return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ AFF_C;
    endfunction : sbox_fwd

    function automatic logic [7:0] sbox_inv(input logic [7:0] s);
        return gf_inv(rotl(s, 1) ^ rotl(s, 3) ^ rotl(s, 6) ^ AFF_INV_C);
    endfunction : sbox_inv

    function automatic logic [GRP_W-1:0] mix(input logic [GRP_W-1:0] v,
                                             input logic [31:0]      coef);
        logic [GRP_W-1:0] o;
        o = '0;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                for (int k = 0; k < 4; k++)
                    o[32*c+8*r +: 8] = o[32*c+8*r +: 8]
                        ^ gf_mul(coef[8*((k-r+4)%4) +: 8], v[32*c+8*k +: 8]);
        return o;
    endfunction : mix

    logic [GRP_W-1:0] sb_f;
    logic [GRP_W-1:0] sr_f;
    logic [GRP_W-1:0] sr_i;
    logic [GRP_W-1:0] sb_i;

    // Forward and inverse paths both run every cycle; op only picks one
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                sb_f[32*c+8*r +: 8] = sbox_fwd(state_in[32*c+8*r +: 8]);
                sr_i[32*c+8*r +: 8] = state_in[32*((c-r+4)%4)+8*r +: 8];
            end
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                sr_f[32*c+8*r +: 8] = sb_f[32*((c+r)%4)+8*r +: 8];
                sb_i[32*c+8*r +: 8] = sbox_inv(sr_i[32*c+8*r +: 8]);
            end
        end
        unique case (op)
            OP_DF: result = sb_i ^ key_in;
            OP_DM: result = mix(sb_i ^ key_in, MIX_INV);
            OP_EF: result = sr_f ^ key_in;
            OP_EM: result = mix(sr_f, MIX_FWD) ^ key_in;
        endcase
    end

endmodule : vru_round
`default_nettype wire

/* hdl/vru_top.sv */
// Purpose: Vector AES round unit: walks element groups, reads, rounds, writes
// Assumes: Register file answers each read with rd_data_valid, any delay
// Notes:   Per-group latency never depends on state or key values
`timescale 1ns/1ns
`default_nettype none

module vru_top
    import vru_pkg::*;
#(
    parameter int VECTOR_REGISTER_LENGTH = 128
) (
    input  wire  logic             core_clk,
    input  wire  logic             sys_rst,
    input  wire  logic             cmd_valid,
    output var   logic             cmd_ready,
    input  wire  vru_cmd_t         cmd,
    output var   logic             rd_valid,
    output var   vru_rd_t          rd,
    input  wire  logic             rd_data_valid,
    input  wire  logic [GRP_W-1:0] rd_state,
    input  wire  logic [GRP_W-1:0] rd_key,
    output var   logic             wr_valid,
    input  wire  logic             wr_ready,
    output var   vru_wr_t          wr,
    output var   logic             done_valid,
    output var   logic             done_illegal
);

    typedef struct packed {
        vru_st_t            st;
        vru_op_t            op;
        logic               vs_form;
        logic [REG_W-1:0]   vd;
        logic [REG_W-1:0]   vs2;
        logic [IDX_W-1:0]   idx;
        logic [IDX_W-1:0]   start;
        logic [IDX_W-1:0]   len;
        logic [GRP_W-1:0]   res;
        logic               cmd_ready;
        logic               rd_valid;
        vru_rd_t            rd;
        logic [1:0]         cnt;
        vru_wr_t [1:0]      buff;
        logic               wr_valid;
        logic               done_valid;
        logic               done_illegal;
    } vru_state_t;

    // Returns {known, scalar form, op}
    function automatic logic [3:0] decode(input logic [31:0] ins);
        logic    known;
        vru_op_t op;
        known = (ins[6:0] == CRYPTO_OPC) && (ins[14:12] == FUNCT_MVV)
              && ins[25]
              && ((ins[31:26] == F6_VV) || (ins[31:26] == F6_VS));
        op = OP_DM;
        unique case (ins[19:15])
            SEL_DM: op = OP_DM;
            SEL_DF: op = OP_DF;
            SEL_EM: op = OP_EM;
            SEL_EF: op = OP_EF;
            default: known = 1'b0;
        endcase
        return {known, ins[31:26] == F6_VS, op};
    endfunction : decode

    function automatic logic too_narrow(input logic signed [2:0] register_grouping);
        int span;
        span = (register_grouping >= 0) ? (VECTOR_REGISTER_LENGTH << register_grouping) : (VECTOR_REGISTER_LENGTH >> (-int'(register_grouping)));
        return span < GRP_W;
    endfunction : too_narrow

    // Destination group against the registers holding key group zero
    function automatic logic overlaps(input logic [REG_W-1:0] vd,
                                      input logic [REG_W-1:0] vs2,
                                      input logic signed [2:0] register_grouping);
        int vd_n;
        int key_n;
        vd_n  = (register_grouping > 0) ? (1 << register_grouping) : 1;
        key_n = (GRP_W > VECTOR_REGISTER_LENGTH) ? (GRP_W / VECTOR_REGISTER_LENGTH) : 1;
        return (int'(vd) < int'(vs2) + key_n) && (int'(vs2) < int'(vd) + vd_n);
    endfunction : overlaps

    vru_state_t       r;
    vru_state_t       n;
    logic [GRP_W-1:0] round_res;
    logic [3:0]       dec;
    logic             cmd_bad;
    logic             pop;
    logic             push;
    logic [IDX_W-1:0] idx_nx;
    vru_wr_t          entry;

    vru_round u_round (
        .op       (r.op),
        .state_in (rd_state),
        .key_in   (rd_key),
        .result   (round_res)
    );

    always_comb begin
        n              = r;
        n.rd_valid     = 1'b0;
        n.done_valid   = 1'b0;
        n.done_illegal = 1'b0;
        dec            = decode(cmd.instr);
        cmd_bad        = !dec[3]
                       || (cmd.sew != SEW_32)
                       || too_narrow(cmd.register_grouping_log2)
                       || (dec[2] && overlaps(cmd.instr[11:7], cmd.instr[24:20],
                                              cmd.register_grouping_log2));
        pop            = r.wr_valid && wr_ready;
        push           = (r.st == S_PUSH) && ((r.cnt != 2'd2) || pop);
        idx_nx         = r.idx + IDX_W'(1);
        entry          = '{dest_state_group: r.vd, grp_idx: r.idx, data: r.res};

        // Two-entry buffer, head always in slot zero
        if (pop) begin
            n.buff[0] = r.buff[1];
            n.cnt     = r.cnt - 2'd1;
        end
        if (push) begin
            n.buff[n.cnt[0]] = entry;
            n.cnt            = n.cnt + 2'd1;
        end

        unique case (r.st)
            S_IDLE: begin
                if (cmd_valid && r.cmd_ready) begin
                    n.op      = vru_op_t'(dec[1:0]);
                    n.vs_form = dec[2];
                    n.vd      = cmd.instr[11:7];
                    n.vs2     = cmd.instr[24:20];
                    n.len     = cmd.vector_length >> GRP_SHIFT;
                    n.start   = cmd.start_index >> GRP_SHIFT;
                    n.idx     = n.start;
                    if (cmd_bad) begin
                        // Refused: no read, no write, stays in S_IDLE
                        n.done_valid   = 1'b1;
                        n.done_illegal = 1'b1;
                    end else if (n.idx >= n.len) begin
                        n.st = S_DRAIN;
                    end else begin
                        n.st       = S_WAIT;
                        n.rd_valid = 1'b1;
                        n.rd       = '{dest_state_group: n.vd,
                                       key_source_group: n.vs2,
                                       state_idx: n.idx,
                                       key_idx: dec[2] ? '0 : n.idx};
                    end
                end
            end
            S_WAIT: begin
                if (rd_data_valid) begin
                    n.res = round_res;
                    n.st  = S_PUSH;
                end
            end
            S_PUSH: begin
                if (push) begin
                    if (idx_nx < r.len) begin
                        n.idx      = idx_nx;
                        n.st       = S_WAIT;
                        n.rd_valid = 1'b1;
                        n.rd       = '{dest_state_group: r.vd,
                                       key_source_group: r.vs2,
                                       state_idx: idx_nx,
                                       key_idx: r.vs_form ? '0 : idx_nx};
                    end else begin
                        n.st = S_DRAIN;
                    end
                end
            end
            S_DRAIN: begin
                // Success only once every group has left the buffer
                if (r.cnt == 2'd0) begin
                    n.done_valid = 1'b1;
                    n.st         = S_IDLE;
                end
            end
        endcase

        n.wr_valid  = (n.cnt != 2'd0);
        n.cmd_ready = (n.st == S_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign cmd_ready    = r.cmd_ready;
    assign rd_valid     = r.rd_valid;
    assign rd           = r.rd;
    assign wr_valid     = r.wr_valid;
    assign wr           = r.buff[0];
    assign done_valid   = r.done_valid;
    assign done_illegal = r.done_illegal;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence cmd_take_s;
        cmd_valid && cmd_ready;
    endsequence

    sequence rsp_taken_s;
        r.st == S_WAIT && rd_data_valid;
    endsequence

    // A command taken in the refusal cycle may start its read at once
    sequence refused_s;
        done_valid && done_illegal && !rd_valid
        ##1 (!rd_valid || $past(cmd_valid)) && !wr_valid;
    endsequence

    sew_reserved_a:
        assert property (cmd_take_s ##0 cmd.sew != SEW_32 |=> refused_s)
        else $error("Element width other than 32 was not refused");

    key_overlap_a:
        assert property (cmd_take_s ##0 dec[3] && dec[2]
                         && overlaps(cmd.instr[11:7], cmd.instr[24:20], cmd.register_grouping_log2)
                         |=> refused_s)
        else $error("Scalar key overlap was not refused");

    narrow_group_a:
        assert property (cmd_take_s ##0 too_narrow(cmd.register_grouping_log2) |=> refused_s)
        else $error("Too narrow grouping was not refused");

    group_range_a:
        assert property (rd_valid |-> rd.state_idx >= r.start && rd.state_idx < r.len)
        else $error("Group read outside the active range");

    key_vector_a:
        assert property (rd_valid && !r.vs_form |-> rd.key_idx == rd.state_idx)
        else $error("Vector form key index does not match state index");

    key_scalar_a:
        assert property (rd_valid && r.vs_form |-> rd.key_idx == '0)
        else $error("Scalar form key index is not zero");

    group_latency_a:
        assert property (rsp_taken_s |=> r.st == S_PUSH)
        else $error("Round result not ready one cycle after the read answer");

    push_step_a:
        assert property (push |=> (rd_valid && r.st == S_WAIT) || r.st == S_DRAIN)
        else $error("Group step after a push took the wrong path");

    write_index_a:
        assert property (push && r.cnt == 2'd0 |=> wr_valid
                         && wr.grp_idx == $past(r.idx) && wr.data == $past(r.res))
        else $error("Result written to the wrong group index");

    retire_empty_a:
        assert property (done_valid && !done_illegal |-> !wr_valid && cmd_ready)
        else $error("Success reported with writes still pending");

    refused_ready_a:
        assert property (done_illegal |-> done_valid && cmd_ready && !rd_valid)
        else $error("Refusal left the unit busy or started a read");

endmodule : vru_top
`default_nettype wire

/* verification/vru_regfile_model.sv */
// Purpose: Register file stand-in that answers group reads and takes writes
// Assumes: Groups are indexed by the low four bits of the group index
// Notes:   Read data lines scramble in every cycle that carries no answer
`timescale 1ns/1ns
`default_nettype none

module vru_regfile_model
    import vru_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             rd_valid,
    input  wire vru_rd_t          rd,
    output var  logic             rd_data_valid,
    output var  logic [GRP_W-1:0] rd_state,
    output var  logic [GRP_W-1:0] rd_key,
    input  wire logic             wr_valid,
    output var  logic             wr_ready,
    input  wire vru_wr_t          wr,
    input  wire logic [1:0]       rsp_delay,
    input  wire logic             stall
);
    logic [GRP_W-1:0] state_mem [0:15];
    logic [GRP_W-1:0] key_mem   [0:15];
    logic [GRP_W-1:0] wr_mem    [0:15];
    logic [IDX_W-1:0] wr_seq    [$];
    logic [REG_W-1:0] wr_dst;
    logic             pend_q;
    logic [1:0]       wait_q;

    assign wr_ready = !stall;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            pend_q        <= 1'b0;
            wait_q        <= 2'h0;
            rd_data_valid <= 1'b0;
            rd_state      <= '0;
            rd_key        <= '1;
        end else begin
            rd_data_valid <= 1'b0;
            rd_state      <= ~rd_state;
            rd_key        <= ~rd_key;
            if (rd_valid) begin
                pend_q <= 1'b1;
                wait_q <= rsp_delay;
            end else if (pend_q && wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else if (pend_q) begin
                pend_q        <= 1'b0;
                rd_data_valid <= 1'b1;
                rd_state      <= state_mem[rd.state_idx[3:0]];
                rd_key        <= key_mem[rd.key_idx[3:0]];
            end
            if (wr_valid && wr_ready) begin
                wr_mem[wr.grp_idx[3:0]] <= wr.data;
                wr_seq.push_back(wr.grp_idx);
                wr_dst <= wr.dest_state_group;
            end
        end
    end
endmodule : vru_regfile_model
`default_nettype wire

/* verification/tb_vector_aes_round_unit.sv */
// Purpose: Self-checking bench for the vector AES round unit
// Assumes: Inputs change at the falling edge of core_clk
// Notes:   Expected groups come from a bench-side round model
`timescale 1ns/1ns
`default_nettype none

module tb_vector_aes_round_unit
    import vru_pkg::*;
;
    logic             core_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             cmd_valid = 1'b0;
    logic             cmd_ready;
    vru_cmd_t         cmd = '0;
    logic             rd_valid;
    vru_rd_t          rd;
    logic             rd_data_valid;
    logic [GRP_W-1:0] rd_state;
    logic [GRP_W-1:0] rd_key;
    logic             wr_valid;
    logic             wr_ready;
    vru_wr_t          wr;
    logic             done_valid;
    logic             done_illegal;
    logic [1:0]       rsp_delay = 2'h0;
    logic             stall = 1'b0;
    int               error_cnt = 0;
    int               check_count = 0;
    int               tick = 0;

    always #5 core_clk = ~core_clk;

    vru_top #(.VECTOR_REGISTER_LENGTH(128)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd(rd),
        .rd_data_valid(rd_data_valid), .rd_state(rd_state), .rd_key(rd_key),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr), .done_valid(done_valid),
        .done_illegal(done_illegal));

    vru_regfile_model m (.core_clk(core_clk), .sys_rst(sys_rst), .rd_valid(rd_valid), .rd(rd),
        .rd_data_valid(rd_data_valid), .rd_state(rd_state), .rd_key(rd_key),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr), .rsp_delay(rsp_delay),
        .stall(stall));

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    always @(posedge core_clk) begin
        tick++;
        if (tick == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(string what, logic [GRP_W-1:0] got, logic [GRP_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i])
                p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
        end
        return p;
    endfunction : gm

    // Field inverse as x to the power 254, zero maps to zero
    function automatic logic [7:0] sb(logic [7:0] x, logic inv);
        logic [7:0] r;
        logic [7:0] p;
        if (inv)
            x = {x[6:0], x[7]} ^ {x[4:0], x[7:5]} ^ {x[1:0], x[7:2]} ^ AFF_INV_C;
        r = 8'h01;
        p = x;
        for (int i = 1; i < 8; i++) begin
            p = gm(p, p);
            r = gm(r, p);
        end
        if (inv)
            return r;
        return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ AFF_C;
    endfunction : sb

    function automatic logic [GRP_W-1:0] ref_round(logic [4:0] sel, logic [GRP_W-1:0] s,
                                                   logic [GRP_W-1:0] k);
        logic [GRP_W-1:0] t;
        logic [GRP_W-1:0] mx;
        logic             inv;
        logic [31:0]      cf;
        inv = !sel[1];
        cf = inv ? MIX_INV : MIX_FWD;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                t[32*c+8*r +: 8] = sb(s[32*((inv ? c - r + 4 : c + r) % 4) + 8*r +: 8], inv);
        if (inv)
            t = t ^ k;
        mx = t;
        if (!sel[0])
            for (int c = 0; c < 4; c++)
                for (int r = 0; r < 4; r++) begin
                    mx[32*c+8*r +: 8] = 8'h00;
                    for (int j = 0; j < 4; j++)
                        mx[32*c+8*r +: 8] ^= gm(cf[8*((j-r)&3) +: 8], t[32*c+8*j +: 8]);
                end
        return inv ? mx : mx ^ k;
    endfunction : ref_round

    function automatic logic [31:0] enc(bit vs, logic [4:0] sel, logic [4:0] ks, logic [4:0] vd);
        return {vs ? F6_VS : F6_VV, 1'b1, ks, sel, FUNCT_MVV, vd, CRYPTO_OPC};
    endfunction : enc

    task automatic fill(logic [7:0] s);
        for (int i = 0; i < 16; i++) begin
            m.state_mem[i] = {16{8'(i * 29) ^ s}} ^ 128'h00112233445566778899aabbccddeeff;
            m.key_mem[i] = {16{8'(i * 53) + s}} ^ 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
        end
    endtask : fill

    task automatic run(logic [31:0] ins, logic [2:0] sew, logic signed [2:0] lm, int vl,
                       int st, int stl, output logic ill, output int cyc);
        int n;
        n = 0;
        m.wr_seq.delete();
        // One edge between commands so cmd_valid is never driven twice in a step
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd <= '{ins, sew, lm, IDX_W'(vl), IDX_W'(st)};
        @(negedge core_clk);
        cmd_valid <= 1'b0;
        cyc = 1;
        while (done_valid !== 1'b1 && cyc < 400) begin
            stall <= (cyc < stl);
            @(negedge core_clk);
            cyc++;
        end
        stall <= 1'b0;
        ill = done_illegal;
        chk("done_valid", done_valid, 1'b1);
        chk("cmd_ready", cmd_ready, 1'b1);
    endtask : run

    task automatic legal(logic [4:0] sel, bit vs, int vl, int st, int stl, logic [4:0] vd,
                         logic [4:0] ks);
        logic ill;
        int   cyc;
        int   g0;
        int   idx;
        run(enc(vs, sel, ks, vd), SEW_32, 3'sd0, vl, st, stl, ill, cyc);
        g0 = st / 4;
        chk("illegal flag", ill, 1'b0);
        chk("write count", m.wr_seq.size(), (vl / 4 > g0) ? vl / 4 - g0 : 0);
        if (vl / 4 > g0) begin
            chk("read dest", rd.dest_state_group, vd);
            chk("read key reg", rd.key_source_group, ks);
            chk("last key index", rd.key_idx, vs ? 0 : vl / 4 - 1);
        end
        foreach (m.wr_seq[i]) begin
            idx = g0 + i;
            chk("group index", m.wr_seq[i], idx);
            chk("dest group", m.wr_dst, vd);
            chk("group data", m.wr_mem[idx], ref_round(sel, m.state_mem[idx], m.key_mem[vs ? 0 : idx]));
        end
    endtask : legal

    task automatic refused(logic [31:0] ins, logic [2:0] sew, logic signed [2:0] lm);
        logic ill;
        int   cyc;
        run(ins, sew, lm, 8, 0, 0, ill, cyc);
        chk("illegal flag", ill, 1'b1);
        chk("illegal writes", m.wr_seq.size(), 0);
    endtask : refused

    task automatic t_rounds();
        logic [4:0] sels [4] = '{SEL_DM, SEL_DF, SEL_EM, SEL_EF};
        for (int f = 0; f < 2; f++)
            for (int s = 0; s < 4; s++) begin
                rsp_delay <= 2'(s);
                legal(sels[s], f[0], 8, 0, 0, 5'h04, 5'h08);
            end
        rsp_delay <= 2'h0;
        legal(SEL_DM, 1'b0, 4, 0, 0, 5'h04, 5'h04);
    endtask : t_rounds

    task automatic t_window();
        legal(SEL_EM, 1'b0, 12, 4, 0, 5'h10, 5'h18);
        legal(SEL_DF, 1'b1, 13, 5, 0, 5'h10, 5'h18);
        legal(SEL_EF, 1'b0, 8, 8, 0, 5'h10, 5'h18);
    endtask : t_window

    task automatic t_stall();
        legal(SEL_EF, 1'b0, 16, 0, 14, 5'h08, 5'h0c);
        legal(SEL_DM, 1'b1, 24, 0, 9, 5'h08, 5'h0c);
    endtask : t_stall

    task automatic t_refused();
        refused(enc(1'b0, SEL_EM, 5'h08, 5'h04), 3'h3, 3'sd0);
        refused(enc(1'b1, SEL_DF, 5'h08, 5'h04), 3'h0, 3'sd0);
        refused(enc(1'b1, SEL_DM, 5'h04, 5'h04), SEW_32, 3'sd0);
        refused(enc(1'b1, SEL_EF, 5'h05, 5'h04), SEW_32, 3'sd1);
        refused(enc(1'b0, SEL_EM, 5'h08, 5'h04), SEW_32, -3'sd1);
        refused(enc(1'b0, 5'h07, 5'h08, 5'h04), SEW_32, 3'sd0);
        legal(SEL_EM, 1'b1, 8, 0, 0, 5'h04, 5'h08);
    endtask : t_refused

    task automatic t_latency();
        logic ill;
        int   c1;
        int   c2;
        fill(8'h00);
        run(enc(1'b0, SEL_EM, 5'h08, 5'h04), SEW_32, 3'sd0, 16, 0, 0, ill, c1);
        fill(8'hc5);
        run(enc(1'b0, SEL_EM, 5'h08, 5'h04), SEW_32, 3'sd0, 16, 0, 0, ill, c2);
        chk("cycle count", c2, c1);
    endtask : t_latency

    initial begin
        fill(8'h3a);
        repeat (3) @(negedge core_clk);
        sys_rst <= 1'b0;
        t_rounds();
        t_window();
        t_stall();
        t_refused();
        t_latency();
        stop_test();
    end
endmodule : tb_vector_aes_round_unit
`default_nettype wire
